// ### core/tmdc_array_end.sv
`timescale 1ns/1ps
`default_nettype none
module tmdc_array_end (
  tmdc_if.device_end lnk
);
  import tmdc_pkg::*;

  // arrays are storage, not reset: contents are undefined until written
  logic [TSA_W-1:0] tsa_mem [TMDC_ENTRIES];
  logic [MRA_W-1:0] mra_mem [TMDC_ENTRIES];
  logic ack;
  logic [TMDC_DW-1:0] rdata;
  logic err;

  wire logic [TMDC_IDX_W-1:0] idx;
  wire logic is_level;
  wire logic is_cfg;
  wire logic [TSA_CHK_W-1:0] tsa_mask;
  wire logic [MRA_PTY_W-1:0] mra_mask;
  wire logic [TSA_W-1:0] tsa_cur;
  wire logic [MRA_W-1:0] mra_cur;
  wire logic tsa_bad;
  wire logic mra_bad;
  wire logic [TMDC_DW-1:0] diag_data;
  wire logic diag_err;

  // only va bits 5:3 are decoded, so reserved bits alias onto one entry
  // index from va
  assign idx = lnk.va[TMDC_VA_IDX_LSB +: TMDC_IDX_W];
  assign is_level = (32'(idx) <= TSA_LAST_LEVEL);
  assign is_cfg = (32'(idx) <= MRA_LAST_CFG);
  assign tsa_mask = lnk.inj_tsa ? {1'b0, lnk.inj_mask} : '0;
  assign mra_mask = lnk.inj_mra ? lnk.inj_mask[MRA_PTY_W-1:0] : '0;
  // only two parity bits exist, so upper mask bits are dropped for the mmu array
  assign tsa_cur = tsa_mem[idx];
  assign mra_cur = mra_mem[idx];

  // queue groups are one bit short; a zero pad lets both layouts share one coder
  function automatic logic [TSA_SEG_W-1:0] seg_hi(input logic [TSA_W-1:0] e, input logic lvl);
    if (lvl) begin
      return {e[TSA_RANGE_LSB +: TSA_RANGE_W], e[TSA_TL_SEG_LSB +: TSA_TL_SEG_W]};
    end
    return {1'b0, e[TSA_Q_SEG_LSB +: TSA_Q_SEG_W]};
  endfunction

  function automatic logic [TSA_SEG_W-1:0] seg_lo(input logic [TSA_W-1:0] e, input logic lvl);
    if (lvl) begin
      return e[TSA_SEG_W-1:0];
    end
    return {1'b0, e[TSA_Q_SEG_W-1:0]};
  endfunction

  function automatic logic [MRA_PTY_W-1:0] mra_par(input logic [MRA_W-1:0] e);
    // one parity bit per 41-bit half
    return {^e[MRA_HALF_W +: MRA_HALF_W], ^e[MRA_HALF_W-1:0]};
  endfunction

  logic [TSA_W-1:0] tsa_img;
  logic [MRA_W-1:0] mra_img;
  // check bits are coded from the stored image, so pads and bit 133 count as stored

  always_comb begin
    tsa_img = '0;
    if (is_level) begin
      tsa_img[TSA_TRAP_NEXT_PROGRAM_COUNTER_LSB +: TSA_PC_W] = lnk.payload[PAY_TRAP_NEXT_PROGRAM_COUNTER_LSB +: TSA_PC_W];
      tsa_img[TSA_TPC_LSB +: TSA_PC_W] = lnk.payload[PAY_TPC_LSB +: TSA_PC_W];
      tsa_img[TSA_TT_LSB +: TSA_TT_W] = lnk.payload[PAY_TT_LSB +: TSA_TT_W];
      tsa_img[TSA_SAVED_TRAP_STATE_LSB +: TSA_SAVED_TRAP_STATE_W] = lnk.payload[PAY_SAVED_TRAP_STATE_LSB +: TSA_SAVED_TRAP_STATE_W];
      tsa_img[TSA_RANGE_LSB +: TSA_RANGE_W] = lnk.payload[PAY_RANGE_LSB +: TSA_RANGE_W];
    end else begin
      tsa_img[TSA_QTAIL0_LSB +: TSA_QPTR_W] = lnk.payload[PAY_QTAIL0_LSB +: TSA_QPTR_W];
      tsa_img[TSA_QTAIL1_LSB +: TSA_QPTR_W] = lnk.payload[PAY_QTAIL1_LSB +: TSA_QPTR_W];
      tsa_img[TSA_QHEAD0_LSB +: TSA_QPTR_W] = lnk.payload[PAY_QHEAD0_LSB +: TSA_QPTR_W];
      tsa_img[TSA_QHEAD1_LSB +: TSA_QPTR_W] = lnk.payload[PAY_QHEAD1_LSB +: TSA_QPTR_W];
    end
    // bit 133 never taken from software
    tsa_img[TSA_HW_RSVD] = 1'b0;
    // the same mask goes into both bytes so either group alone reports
    // armed write stores altered check bits
    tsa_img[TSA_CHK_HI_LSB +: TSA_CHK_W] = tmdc_ecc(seg_hi(tsa_img, is_level)) ^ tsa_mask;
    tsa_img[TSA_CHK_LO_LSB +: TSA_CHK_W] = tmdc_ecc(seg_lo(tsa_img, is_level)) ^ tsa_mask;
  end

  always_comb begin
    mra_img = '0;
    if (is_cfg) begin
      mra_img[MRA_CFG0_LSB +: MRA_CFG_W] = lnk.payload[PAY_CFG0_LSB +: MRA_CFG_W];
      mra_img[MRA_CFG1_LSB +: MRA_CFG_W] = lnk.payload[PAY_CFG1_LSB +: MRA_CFG_W];
    end else begin
      // range and offset, bit 81 unused
      mra_img[MRA_RANGE_LSB +: MRA_RANGE_W] = lnk.payload[PAY_RANGE_REG_LSB +: MRA_RANGE_W];
      mra_img[MRA_OFFSET_LSB +: MRA_OFFSET_W] = lnk.payload[PAY_OFFSET_LSB +: MRA_OFFSET_W];
    end
    {mra_img[MRA_PAR_HI], mra_img[MRA_PAR_LO]} = mra_par(mra_img) ^ mra_mask;
  end

  // functional checks; correctable checking can be switched off for repair
  // check enable gates reporting
  assign tsa_bad = lnk.check_en &&
    (({tsa_cur[TSA_CHK_HI_LSB +: TSA_CHK_W], tsa_cur[TSA_CHK_LO_LSB +: TSA_CHK_W]}) !=
     {tmdc_ecc(seg_hi(tsa_cur, is_level)), tmdc_ecc(seg_lo(tsa_cur, is_level))});
  // parity has no enable: repair is a full rewrite from a clean copy
  assign mra_bad = ({mra_cur[MRA_PAR_HI], mra_cur[MRA_PAR_LO]} != mra_par(mra_cur));

  assign diag_data = (lnk.asi == TMDC_ASI_TRAP_STACK) ?
    TMDC_DW'({tsa_cur[TSA_CHK_HI_LSB +: TSA_CHK_W], tsa_cur[TSA_CHK_LO_LSB +: TSA_CHK_W]}) :
    (lnk.asi == TMDC_ASI_MMU_CFG) ?
    TMDC_DW'({mra_cur[MRA_PAR_HI], mra_cur[MRA_PAR_LO]}) : '0;
  // diagnostic reads compare nothing; err only marks a foreign address space
  // no ecc error on diag read
  // no parity error on diag read
  assign diag_err = (lnk.asi != TMDC_ASI_TRAP_STACK) && (lnk.asi != TMDC_ASI_MMU_CFG);

  // a write lands at the request edge; a read of the same entry sees it one op later
  always_ff @(posedge lnk.pclk) begin
    if (lnk.req && lnk.op == TMDC_OP_TSA_WR) begin
      tsa_mem[idx] <= tsa_img;
    end
    if (lnk.req && lnk.op == TMDC_OP_MRA_WR) begin
      mra_mem[idx] <= mra_img;
    end
  end

  // functional reads return the low word only; wider fields show through check bits
  logic [TMDC_DW-1:0] next_rdata;
  logic next_err;

  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    unique case (lnk.op)
      TMDC_OP_DIAG: begin
        next_rdata = diag_data;
        next_err = diag_err;
      end
      TMDC_OP_TSA_RD: begin
        next_rdata = tsa_cur[TMDC_DW-1:0];
        next_err = tsa_bad;
      end
      TMDC_OP_MRA_RD: begin
        next_rdata = mra_cur[TMDC_DW-1:0];
        next_err = mra_bad;
      end
      default: begin
        next_rdata = '0;
        next_err = 1'b0;
      end
    endcase
  end

  // writes answer too, with err low, so the host clears busy the same way for every op
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      ack <= 1'b0;
      rdata <= '0;
      err <= 1'b0;
    end else begin
      ack <= lnk.req;
      if (lnk.req) begin
        rdata <= next_rdata;
        err <= next_err;
      end
    end
  end

  assign lnk.ack = ack;
  assign lnk.rdata = rdata;
  assign lnk.err = err;
endmodule
`default_nettype wire

// ### core/tmdc_pkg.sv
package tmdc_pkg;
  localparam int TMDC_DW = 64;
  localparam int TMDC_IDX_W = 3;
  localparam int TMDC_ENTRIES = 8;
  localparam logic [7:0] TMDC_ASI_TRAP_STACK = 8'h5b;
  localparam logic [7:0] TMDC_ASI_MMU_CFG = 8'h51;
  localparam int TMDC_VA_IDX_LSB = 3;

  localparam int TSA_W = 152;
  localparam int TSA_SEG_W = 68;
  localparam int TSA_CHK_W = 8;
  localparam int TSA_CHK_HI_LSB = 142;
  localparam int TSA_CHK_LO_LSB = 134;
  localparam int TSA_DIAG_W = 16;
  localparam int TSA_RANGE_LSB = 150;
  localparam int TSA_RANGE_W = 2;
  localparam int TSA_HW_RSVD = 133;
  localparam int TSA_TL_SEG_LSB = 68;
  localparam int TSA_TL_SEG_W = 66;
  localparam int TSA_Q_SEG_LSB = 67;
  localparam int TSA_Q_SEG_W = 67;
  localparam int TSA_TRAP_NEXT_PROGRAM_COUNTER_LSB = 0;
  localparam int TSA_TPC_LSB = 46;
  localparam int TSA_PC_W = 46;
  localparam int TSA_TT_LSB = 92;
  localparam int TSA_TT_W = 9;
  localparam int TSA_SAVED_TRAP_STATE_LSB = 101;
  localparam int TSA_SAVED_TRAP_STATE_W = 32;
  localparam int TSA_LAST_LEVEL = 5;
  localparam int TSA_QTAIL0_LSB = 80;
  localparam int TSA_QTAIL1_LSB = 68;
  localparam int TSA_QHEAD0_LSB = 34;
  localparam int TSA_QHEAD1_LSB = 22;
  localparam int TSA_QPTR_W = 12;

  localparam int MRA_W = 84;
  localparam int MRA_PAR_HI = 83;
  localparam int MRA_PAR_LO = 82;
  localparam int MRA_HALF_W = 41;
  localparam int MRA_PTY_W = 2;
  localparam int MRA_LAST_CFG = 3;
  localparam int MRA_CFG_W = 38;
  localparam int MRA_CFG0_LSB = 39;
  localparam int MRA_CFG1_LSB = 0;
  localparam int MRA_RANGE_LSB = 27;
  localparam int MRA_RANGE_W = 54;
  localparam int MRA_OFFSET_LSB = 0;
  localparam int MRA_OFFSET_W = 27;

  // logical payload carried with a write
  localparam int PAY_W = 135;
  localparam int PAY_TRAP_NEXT_PROGRAM_COUNTER_LSB = 0;
  localparam int PAY_TPC_LSB = 46;
  localparam int PAY_TT_LSB = 92;
  localparam int PAY_SAVED_TRAP_STATE_LSB = 101;
  localparam int PAY_RANGE_LSB = 133;
  localparam int PAY_QHEAD1_LSB = 0;
  localparam int PAY_QHEAD0_LSB = 12;
  localparam int PAY_QTAIL1_LSB = 24;
  localparam int PAY_QTAIL0_LSB = 36;
  localparam int PAY_CFG1_LSB = 0;
  localparam int PAY_CFG0_LSB = 38;
  localparam int PAY_OFFSET_LSB = 0;
  localparam int PAY_RANGE_REG_LSB = 27;

  localparam int INJ_MASK_W = 7;

  typedef enum logic [2:0] {
    TMDC_OP_DIAG = 3'b000,
    TMDC_OP_TSA_WR = 3'b001,
    TMDC_OP_MRA_WR = 3'b010,
    TMDC_OP_TSA_RD = 3'b011,
    TMDC_OP_MRA_RD = 3'b100
  } tmdc_op_e;

  // host register map, byte addresses on apb
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_DATA0 = 8'h08;
  localparam int DATA_WORDS = 5;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_RDATA_LO = 8'h20;
  localparam logic [7:0] REG_RDATA_HI = 8'h24;
  localparam int CTRL_INJ_TSA = 0;
  localparam int CTRL_INJ_MRA = 1;
  localparam int CTRL_CHECK_EN = 2;
  localparam int CTRL_MASK_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 4;
  localparam int CMD_ASI_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;

  function automatic logic [TSA_CHK_W-1:0] tmdc_ecc(input logic [TSA_SEG_W-1:0] d);
    logic [TSA_CHK_W-1:0] c;
    logic [7:0] pos;
    c = '0;
    for (int i = 0; i < TSA_SEG_W; i++) begin
      pos = 8'(i + 1);
      for (int k = 0; k < TSA_CHK_W - 1; k++) begin
        if (pos[k]) begin
          c[k] = c[k] ^ d[i];
        end
      end
    end
    c[TSA_CHK_W-1] = ^d;
    return c;
  endfunction
endpackage

// ### core/tmdc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmdc_if (
  input wire logic pclk,
  input wire logic presetn
);
  import tmdc_pkg::*;
  logic req;
  tmdc_op_e op;
  logic [7:0] asi;
  logic [TMDC_DW-1:0] va;
  logic [PAY_W-1:0] payload;
  logic inj_tsa;
  logic inj_mra;
  logic [INJ_MASK_W-1:0] inj_mask;
  logic check_en;
  logic ack;
  logic [TMDC_DW-1:0] rdata;
  logic err;

  modport device_end (
    input pclk, presetn, req, op, asi, va, payload, inj_tsa, inj_mra, inj_mask, check_en,
    output ack, rdata, err
  );
  modport host_end (
    input pclk, presetn, ack, rdata, err,
    output req, op, asi, va, payload, inj_tsa, inj_mra, inj_mask, check_en
  );
endinterface
`default_nettype wire

// ### core/tmdc_pipe_end.sv
`timescale 1ns/1ps
`default_nettype none
module tmdc_pipe_end (
  tmdc_if.host_end lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tmdc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import tmdc_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] data_reg [DATA_WORDS];
  logic busy;
  logic err_seen;
  logic [TMDC_DW-1:0] result;
  logic req;
  tmdc_op_e op;
  logic [7:0] asi;
  logic [TMDC_IDX_W-1:0] idx;

  wire logic acc;
  wire logic wr;
  wire logic hit_ctrl;
  wire logic hit_cmd;
  wire logic hit_stat;
  wire logic hit_lo;
  wire logic hit_hi;
  wire logic [DATA_WORDS-1:0] hit_data;
  wire logic mapped;
  wire logic [31*DATA_WORDS+DATA_WORDS-1:0] data_flat;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit_ctrl = (paddr == REG_CTRL);
  assign hit_cmd = (paddr == REG_CMD);
  assign hit_stat = (paddr == REG_STATUS);
  assign hit_lo = (paddr == REG_RDATA_LO);
  assign hit_hi = (paddr == REG_RDATA_HI);

  genvar g;
  generate
    for (g = 0; g < DATA_WORDS; g++) begin : g_data
      assign hit_data[g] = (paddr == REG_DATA0 + 8'(4 * g));
      assign data_flat[32*g +: 32] = data_reg[g];
      always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
        if (!lnk.presetn) begin
          data_reg[g] <= '0;
        end else if (wr && pready && hit_data[g]) begin
          data_reg[g] <= pwdata;
        end
      end
    end
  endgenerate

  assign mapped = hit_ctrl || hit_cmd || hit_stat || hit_lo || hit_hi || (|hit_data);

  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = '0;
    if (hit_ctrl) next_prdata = ctrl;
    if (hit_stat) next_prdata = 32'({err_seen, busy});
    if (hit_lo) next_prdata = result[31:0];
    if (hit_hi) next_prdata = result[63:32];
    for (int i = 0; i < DATA_WORDS; i++) begin
      if (hit_data[i]) next_prdata = data_reg[i];
    end
  end

  // one wait state: data and error come from flops in the access cycle's next edge
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= next_prdata;
      pslverr <= acc && !pready && !mapped;
    end
  end

  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr && pready && hit_ctrl) begin
      ctrl <= pwdata;
    end
  end

  // a command written while one is outstanding is dropped
  always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
    if (!lnk.presetn) begin
      busy <= 1'b0;
      req <= 1'b0;
      op <= TMDC_OP_DIAG;
      asi <= '0;
      idx <= '0;
      err_seen <= 1'b0;
      result <= '0;
    end else begin
      req <= 1'b0;
      // writes land only on the edge that completes the transfer, with pready high
      if (wr && pready && hit_cmd && !busy) begin
        busy <= 1'b1;
        req <= 1'b1;
        op <= tmdc_op_e'(pwdata[CMD_OP_LSB +: 3]);
        idx <= pwdata[CMD_IDX_LSB +: TMDC_IDX_W];
        asi <= pwdata[CMD_ASI_LSB +: 8];
      end else if (lnk.ack) begin
        busy <= 1'b0;
        err_seen <= lnk.err;
        result <= lnk.rdata;
      end
    end
  end

  assign lnk.req = req;
  assign lnk.op = op;
  assign lnk.asi = asi;
  assign lnk.va = TMDC_DW'({idx, 3'h0});
  assign lnk.payload = data_flat[PAY_W-1:0];
  assign lnk.inj_tsa = ctrl[CTRL_INJ_TSA];
  assign lnk.inj_mra = ctrl[CTRL_INJ_MRA];
  assign lnk.inj_mask = ctrl[CTRL_MASK_LSB +: INJ_MASK_W];
  assign lnk.check_en = ctrl[CTRL_CHECK_EN];
endmodule
`default_nettype wire

// ### verification/tmdc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tmdc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire tmdc_pkg::tmdc_op_e op,
  input wire logic [7:0] asi,
  input wire logic [tmdc_pkg::TMDC_DW-1:0] va,
  input wire logic inj_tsa,
  input wire logic inj_mra,
  input wire logic [tmdc_pkg::INJ_MASK_W-1:0] inj_mask,
  input wire logic check_en,
  input wire logic ack,
  input wire logic [tmdc_pkg::TMDC_DW-1:0] rdata,
  input wire logic err
);
  import tmdc_pkg::*;
  logic [7:0] tsa_bad;
  logic [7:0] mra_bad;
  wire [2:0] idx = va[5:3];
  wire is_diag = req && op == TMDC_OP_DIAG;
  wire known_asi = asi == TMDC_ASI_TRAP_STACK || asi == TMDC_ASI_MMU_CFG;
  // per entry memory of whether the last write stored corrupted check bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsa_bad <= '0;
      mra_bad <= '0;
    end else if (req && op == TMDC_OP_TSA_WR) begin
      tsa_bad[idx] <= inj_tsa && |inj_mask;
    end else if (req && op == TMDC_OP_MRA_WR) begin
      mra_bad[idx] <= inj_mra && |inj_mask[1:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_tsa_diag;
    is_diag && asi == TMDC_ASI_TRAP_STACK ##1 ack;
  endsequence
  sequence s_mra_diag;
    is_diag && asi == TMDC_ASI_MMU_CFG ##1 ack;
  endsequence
  sequence s_bad_diag;
    is_diag && !known_asi ##1 ack;
  endsequence
  sequence s_write;
    req && (op == TMDC_OP_TSA_WR || op == TMDC_OP_MRA_WR) ##1 ack;
  endsequence
  sequence s_tsa_rd;
    req && op == TMDC_OP_TSA_RD && check_en ##1 ack;
  endsequence
  sequence s_mra_rd;
    req && op == TMDC_OP_MRA_RD ##1 ack;
  endsequence
  a_ack_one_later: assert property (ack == $past(req))
    else $error("ack not one cycle after req");
  a_tsa_diag_clean: assert property (s_tsa_diag |-> rdata[63:16] == '0 && !err)
    else $error("trap stack diag read dirty");
  a_mra_diag_clean: assert property (s_mra_diag |-> rdata[63:2] == '0 && !err)
    else $error("mmu diag read dirty");
  a_bad_asi_err: assert property (s_bad_diag |-> err)
    else $error("unmapped asi not flagged");
  a_result_holds: assert property (!ack |-> $stable(rdata) && $stable(err))
    else $error("result changed without ack");
  a_write_no_err: assert property (s_write |-> !err)
    else $error("write reported error");
  a_tsa_inject_err: assert property (s_tsa_rd |-> err == $past(tsa_bad[idx]))
    else $error("trap stack check error wrong");
  a_mra_inject_err: assert property (s_mra_rd |-> err == $past(mra_bad[idx]))
    else $error("mmu parity error wrong");
endmodule
`default_nettype wire

// ### verification/trap_and_mmu_array_diag_check_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module trap_and_mmu_array_diag_check_tb_top;
  import tmdc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int err_count = 0;
  int num_checks = 0;
  tmdc_if lnk (.pclk(pclk), .presetn(presetn));
  tmdc_array_end tmdc_array_end_i (.lnk(lnk.device_end));
  tmdc_pipe_end tmdc_pipe_end_i (.lnk(lnk.host_end), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  tmdc_properties tmdc_properties_i (.pclk(pclk), .presetn(presetn), .req(lnk.req),
    .op(lnk.op), .asi(lnk.asi), .va(lnk.va), .inj_tsa(lnk.inj_tsa), .inj_mra(lnk.inj_mra),
    .inj_mask(lnk.inj_mask), .check_en(lnk.check_en), .ack(lnk.ack), .rdata(lnk.rdata),
    .err(lnk.err));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch %s exp %h got %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic pe);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
    q = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic pe;
    apb(1'b1, a, d, q, pe);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic pe;
    apb(1'b0, a, 32'h0, q, pe);
  endtask
  task automatic load(input logic [134:0] p);
    logic [159:0] x;
    x = 160'(p);
    for (int k = 0; k < DATA_WORDS; k++) begin
      wr(8'(REG_DATA0 + 4 * k), x[32 * k +: 32]);
    end
  endtask
  // busy polling is bounded so a stuck command cannot hang the run
  task automatic cmd(input tmdc_op_e o, input logic [2:0] ix, input logic [7:0] as,
      output logic [63:0] r, output logic e);
    logic [31:0] s;
    int n;
    wr(REG_CMD, {16'h0, as, 1'b0, ix, 1'b0, o});
    n = 0;
    s = 32'h1;
    while (s[STAT_BUSY] !== 1'b0) begin
      rd(REG_STATUS, s);
      n++;
      if (n > 20) begin
        err_count++;
        stop_test();
      end
    end
    e = s[STAT_ERR];
    rd(REG_RDATA_LO, r[31:0]);
    rd(REG_RDATA_HI, r[63:32]);
  endtask
  function automatic logic [134:0] pat(input int i);
    logic [31:0] w;
    w = 32'h9e3779b9 + 32'(i) * 32'h01030507;
    return 135'({w, ~w, w ^ 32'h5a5a5a5a, ~w, w});
  endfunction
  function automatic logic [7:0] hm(input logic [67:0] d);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < 68; i++) begin
      for (int k = 0; k < 7; k++) begin
        if ((((i + 1) >> k) & 1) == 1) c[k] ^= d[i];
      end
    end
    c[7] = ^d;
    return c;
  endfunction
  function automatic logic [151:0] tsa_ent(input logic [2:0] ix, input logic [134:0] p);
    logic [151:0] e;
    logic [67:0] hi;
    logic [67:0] lo;
    e = '0;
    if (ix < 3'h6) begin
      e[132:0] = p[132:0];
      e[151:150] = p[134:133];
      hi = {e[151:150], e[133:68]};
      lo = e[67:0];
    end else begin
      e[33:22] = p[11:0];
      e[45:34] = p[23:12];
      e[79:68] = p[35:24];
      e[91:80] = p[47:36];
      hi = {1'b0, e[133:67]};
      lo = {1'b0, e[66:0]};
    end
    e[149:142] = hm(hi);
    e[141:134] = hm(lo);
    return e;
  endfunction
  function automatic logic [83:0] mra_ent(input logic [2:0] ix, input logic [134:0] p);
    logic [83:0] e;
    e = '0;
    if (ix < 3'h4) begin
      e[37:0] = p[37:0];
      e[76:39] = p[75:38];
    end else begin
      e[80:0] = p[80:0];
    end
    e[83] = ^e[81:41];
    e[82] = ^e[40:0];
    return e;
  endfunction
  task automatic t_regs();
    logic [31:0] q;
    logic pe;
    apb(1'b0, REG_CTRL, 32'h0, q, pe);
    chk("ctrl_reset", 64'(q), 64'h4);
    apb(1'b1, 8'h30, 32'hffffffff, q, pe);
    chk("unmapped_wr_err", {63'h0, pe}, 64'h1);
    apb(1'b0, 8'h30, 32'h0, q, pe);
    chk("unmapped_rd", {31'h0, pe, q}, 64'h1_0000_0000);
  endtask
  task automatic t_mra();
    logic [63:0] r;
    logic e;
    logic [83:0] m;
    for (int i = 0; i < 8; i++) begin
      m = mra_ent(3'(i), pat(i));
      load(pat(i));
      cmd(TMDC_OP_MRA_WR, 3'(i), 8'h00, r, e);
      cmd(TMDC_OP_DIAG, 3'(i), TMDC_ASI_MMU_CFG, r, e);
      chk("mra_pty", r, {62'h0, m[83:82]});
      chk("mra_diag_err", {63'h0, e}, 64'h0);
      cmd(TMDC_OP_MRA_RD, 3'(i), 8'h00, r, e);
      chk("mra_data", r, m[63:0]);
      chk("mra_rd_err", {63'h0, e}, 64'h0);
    end
  endtask
  task automatic t_tsa();
    logic [63:0] r;
    logic e;
    logic [151:0] t;
    for (int i = 0; i < 8; i++) begin
      t = tsa_ent(3'(i), pat(i + 20));
      load(pat(i + 20));
      cmd(TMDC_OP_TSA_WR, 3'(i), 8'h00, r, e);
      cmd(TMDC_OP_DIAG, 3'(i), TMDC_ASI_TRAP_STACK, r, e);
      chk("tsa_ecc", r, {48'h0, t[149:134]});
      chk("tsa_diag_err", {63'h0, e}, 64'h0);
      cmd(TMDC_OP_TSA_RD, 3'(i), 8'h00, r, e);
      chk("tsa_data", r, t[63:0]);
      chk("tsa_rd_err", {63'h0, e}, 64'h0);
    end
  endtask
  task automatic t_inj();
    logic [63:0] r;
    logic e;
    logic [83:0] m;
    logic [151:0] t;
    m = mra_ent(3'h2, pat(9));
    wr(REG_CTRL, 32'h0000_0106);
    load(pat(9));
    cmd(TMDC_OP_MRA_WR, 3'h2, 8'h00, r, e);
    cmd(TMDC_OP_DIAG, 3'h2, TMDC_ASI_MMU_CFG, r, e);
    chk("mra_inj_pty", r, {62'h0, m[83:82] ^ 2'b01});
    cmd(TMDC_OP_MRA_RD, 3'h2, 8'h00, r, e);
    chk("mra_inj_err", {63'h0, e}, 64'h1);
    wr(REG_CTRL, 32'h4);
    cmd(TMDC_OP_MRA_WR, 3'h2, 8'h00, r, e);
    cmd(TMDC_OP_MRA_RD, 3'h2, 8'h00, r, e);
    chk("mra_fix_err", {63'h0, e}, 64'h0);
    t = tsa_ent(3'h1, pat(10));
    wr(REG_CTRL, 32'h0000_0505);
    load(pat(10));
    cmd(TMDC_OP_TSA_WR, 3'h1, 8'h00, r, e);
    cmd(TMDC_OP_DIAG, 3'h1, TMDC_ASI_TRAP_STACK, r, e);
    chk("tsa_inj_ecc", r, {48'h0, t[149:134] ^ 16'h0505});
    cmd(TMDC_OP_TSA_RD, 3'h1, 8'h00, r, e);
    chk("tsa_inj_err", {63'h0, e}, 64'h1);
    // repair: checking off, read the entry, rewrite it from the payload still held in the data registers
    wr(REG_CTRL, 32'h0);
    cmd(TMDC_OP_TSA_RD, 3'h1, 8'h00, r, e);
    cmd(TMDC_OP_TSA_WR, 3'h1, 8'h00, r, e);
    wr(REG_CTRL, 32'h4);
    cmd(TMDC_OP_TSA_RD, 3'h1, 8'h00, r, e);
    chk("tsa_fix_err", {63'h0, e}, 64'h0);
    cmd(TMDC_OP_DIAG, 3'h1, TMDC_ASI_TRAP_STACK, r, e);
    chk("tsa_fix_ecc", r, {48'h0, t[149:134]});
    cmd(TMDC_OP_DIAG, 3'h3, 8'h5a, r, e);
    chk("bad_asi_err", {63'h0, e}, 64'h1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mra();
    t_tsa();
    t_inj();
    stop_test();
  end
endmodule
`default_nettype wire
